// >>> src/gps_pkg.sv
// Purpose: shared constants for the graphics function status and revision registers
// Assumes: byte-addressed configuration space, dword-wide data path
// Notes:   status shares the dword at 04h with the command word

`default_nettype none

package gps_pkg;

   // ********************************************
   // configuration offsets
   // ********************************************
   localparam logic [7:0]  CMD_OFFSET      = 8'h04;
   localparam logic [7:0]  STS_OFFSET      = 8'h06;
   localparam logic [7:0]  REV_OFFSET      = 8'h08;
   localparam logic [7:0]  CAP_PTR_OFFSET  = 8'h34;

   // ********************************************
   // status word layout and reset value
   // ********************************************
   localparam logic [15:0] STS_RESET       = 16'h0090;
   localparam logic [15:0] STS_FIXED       = 16'h0090;
   localparam int          STS_INT_BIT     = 3;
   localparam int          STS_LANE_LO     = 16;
   localparam int          STS_BYTE_LANE   = 2;
   localparam int          STS_RSVD_HI     = 2;

   // ********************************************
   // command word layout
   // ********************************************
   localparam int          CMD_INT_DIS_BIT = 10;
   localparam int          CMD_BYTE_LANE   = 1;
   localparam logic        CMD_INT_DIS_RST = 1'b0;

   // ********************************************
   // function numbers sharing the revision value
   // ********************************************
   localparam logic [2:0]  FUNC_PRIMARY    = 3'h0;
   localparam logic [2:0]  FUNC_SECONDARY  = 3'h1;

   localparam logic [31:0] RDATA_RESET     = 32'h0000_0000;
   localparam logic        INT_STS_RST     = 1'b0;

endpackage

`default_nettype wire

// >>> src/gps_cfg_decode.sv
// Purpose: address and byte-lane decode for configuration cycles
// Assumes: address is a byte offset, low two bits ignored
// Notes:   purely combinational

`timescale 1ns/10ps
`default_nettype none

module gps_cfg_decode (
   input  wire logic [7:0] i_addr,
   input  wire logic [2:0] i_func,
   input  wire logic       i_wr,
   input  wire logic [3:0] i_be,
   output logic            o_func_ok,
   output logic            o_hit_cmd_sts,
   output logic            o_hit_rev,
   output logic            o_wr_cmd_hi,
   output logic            o_wr_sts_lo
);

   wire logic [7:0] dw_addr;
   wire logic       wr_cs;

   // both functions answer with the same registers
   assign o_func_ok     = (i_func == gps_pkg::FUNC_PRIMARY) |
                          (i_func == gps_pkg::FUNC_SECONDARY);
   assign dw_addr       = {i_addr[7:2], 2'b00};
   assign o_hit_cmd_sts = o_func_ok & (dw_addr == gps_pkg::CMD_OFFSET);
   assign o_hit_rev     = o_func_ok & (dw_addr == gps_pkg::REV_OFFSET);
   assign wr_cs         = i_wr & o_hit_cmd_sts;
   assign o_wr_cmd_hi   = wr_cs & i_be[gps_pkg::CMD_BYTE_LANE];
   assign o_wr_sts_lo   = wr_cs & i_be[gps_pkg::STS_BYTE_LANE];

endmodule

`default_nettype wire

// >>> src/gps_int_flag.sv
// Purpose: sticky interrupt status bit and legacy interrupt gate
// Assumes: event is a one-cycle pulse from the function's engine
// Notes:   a new event beats a clear landing in the same cycle

`timescale 1ns/10ps
`default_nettype none

module gps_int_flag (
   input  wire logic i_ref_clk,
   input  wire logic i_reset_n,
   input  wire logic i_event,
   input  wire logic i_clear,
   input  wire logic i_disable,
   output logic      o_status,
   output logic      o_intx_n
);

   logic status_reg;
   logic status_next;
   logic intx_n_reg;
   logic intx_n_next;

   // set wins so no event is lost under a clear
   assign status_next = i_event | (status_reg & ~i_clear);
   // disable masks only the pin, never the status
   assign intx_n_next = ~(status_reg & ~i_disable);

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         status_reg <= gps_pkg::INT_STS_RST;
         intx_n_reg <= 1'b1;
      end else begin
         status_reg <= status_next;
         intx_n_reg <= intx_n_next;
      end
   end

   assign o_status = status_reg;
   assign o_intx_n = intx_n_reg;

endmodule

`default_nettype wire

// >>> src/gps_regs.sv
// Purpose: status and revision registers of the graphics configuration function
// Assumes: one configuration request per cycle at most, synchronous to i_ref_clk
// Notes:   every request is answered one cycle later; unmapped reads return zero

`timescale 1ns/10ps
`default_nettype none

module gps_regs #(
   // arbitrary value, replaced per silicon revision
   parameter logic [7:0] REVISION = 8'h5a
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_cfg_rd,
   input  wire logic        i_cfg_wr,
   input  wire logic [7:0]  i_cfg_addr,
   input  wire logic [2:0]  i_cfg_func,
   input  wire logic [3:0]  i_cfg_be,
   input  wire logic [31:0] i_cfg_wdata,
   input  wire logic        i_int_event,
   output logic             o_cfg_ack,
   output logic [31:0]      o_cfg_rdata,
   output logic             o_intx_n,
   output logic             o_serr_n_out,
   output logic             o_serr_n_oe,
   output logic             o_int_disable
);

   // ********************************************
   // decode
   // ********************************************
   wire logic        func_ok;
   wire logic        hit_cmd_sts;
   wire logic        hit_rev;
   wire logic        wr_cmd_hi;
   wire logic        wr_sts_lo;
   wire logic        req;
   wire logic        rd_take;
   wire logic        sts_clear;
   wire logic        int_status;
   wire logic [15:0] sts_word;
   wire logic [15:0] cmd_word;
   wire logic [31:0] cmd_sts_dw;
   wire logic [31:0] rev_dw;
   wire logic [31:0] rd_mux;

   gps_cfg_decode u_decode (
      .i_addr        (i_cfg_addr),
      .i_func        (i_cfg_func),
      .i_wr          (i_cfg_wr),
      .i_be          (i_cfg_be),
      .o_func_ok     (func_ok),
      .o_hit_cmd_sts (hit_cmd_sts),
      .o_hit_rev     (hit_rev),
      .o_wr_cmd_hi   (wr_cmd_hi),
      .o_wr_sts_lo   (wr_sts_lo)
   );

   // a write wins when both strobes arrive together
   assign req     = i_cfg_rd | i_cfg_wr;
   assign rd_take = i_cfg_rd & ~i_cfg_wr;

   // ********************************************
   // command interrupt disable
   // ********************************************
   logic int_dis_reg;
   logic int_dis_next;

   assign int_dis_next = wr_cmd_hi ? i_cfg_wdata[gps_pkg::CMD_INT_DIS_BIT] : int_dis_reg;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         int_dis_reg <= gps_pkg::CMD_INT_DIS_RST;
      end else begin
         int_dis_reg <= int_dis_next;
      end
   end

   // ********************************************
   // interrupt status
   // ********************************************
   // clear on one only
   assign sts_clear = wr_sts_lo & i_cfg_wdata[gps_pkg::STS_LANE_LO + gps_pkg::STS_INT_BIT];

   gps_int_flag u_int_flag (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .i_event   (i_int_event),
      .i_clear   (sts_clear),
      .i_disable (int_dis_reg),
      .o_status  (int_status),
      .o_intx_n  (o_intx_n)
   );

   // ********************************************
   // status word assembly
   // ********************************************
   // fixed bits, with the interrupt status bit left live
   genvar b;
   generate
      for (b = 0; b < 16; b++) begin : g_sts
         if (b == gps_pkg::STS_INT_BIT) begin : g_live
            assign sts_word[b] = int_status;
         end else begin : g_fixed
            assign sts_word[b] = gps_pkg::STS_FIXED[b];
            a_fixed_bit: assert property (
               @(posedge i_ref_clk) disable iff (!i_reset_n)
               sts_word[b] == gps_pkg::STS_FIXED[b])
               else $error("fixed status bit changed");
         end
      end
   endgenerate

   // only the disable bit lives in this command word
   assign cmd_word   = {5'h00, int_dis_reg, 10'h000};
   assign cmd_sts_dw = {sts_word, cmd_word};
   assign rev_dw     = {24'h00_0000, REVISION};
   assign rd_mux     = hit_cmd_sts ? cmd_sts_dw :
                       hit_rev     ? rev_dw     : gps_pkg::RDATA_RESET;

   // ********************************************
   // answer path
   // ********************************************
   logic        ack_reg;
   logic        ack_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   assign ack_next   = req;
   assign rdata_next = rd_take ? rd_mux : gps_pkg::RDATA_RESET;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ack_reg   <= 1'b0;
         rdata_reg <= gps_pkg::RDATA_RESET;
      end else begin
         ack_reg   <= ack_next;
         rdata_reg <= rdata_next;
      end
   end

   // ********************************************
   // error pin, never driven
   // ********************************************
   logic serr_oe_reg;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         serr_oe_reg <= 1'b0;
      end else begin
         serr_oe_reg <= 1'b0;
      end
   end

   assign o_cfg_ack     = ack_reg;
   assign o_cfg_rdata   = rdata_reg;
   assign o_serr_n_out  = serr_oe_reg;
   assign o_serr_n_oe   = serr_oe_reg;
   assign o_int_disable = int_dis_reg;

   // ********************************************
   // checks
   // ********************************************
   logic first_reg;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         first_reg <= 1'b1;
      end else begin
         first_reg <= 1'b0;
      end
   end

   a_sts_reset_val: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      first_reg |-> (sts_word == gps_pkg::STS_RESET) && !int_dis_reg)
      else $error("status or disable wrong after reset");

   a_sts_read_back: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && hit_cmd_sts && !i_int_event && !int_status
      |=> o_cfg_rdata[31:16] == gps_pkg::STS_RESET)
      else $error("status read does not match reset value");

   a_serr_released: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !o_serr_n_oe && !o_serr_n_out)
      else $error("system error pin driven");

   a_ack_each_req: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      req ##1 req |=> o_cfg_ack && $past(o_cfg_ack))
      else $error("back to back request lost");

   a_ack_no_req: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !req |=> !o_cfg_ack && (o_cfg_rdata == 32'h0000_0000))
      else $error("answer without request");

   a_int_set: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_int_event |=> int_status)
      else $error("interrupt status not set by event");

   a_int_clear: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      sts_clear && !i_int_event |=> !int_status)
      else $error("interrupt status not cleared by one");

   a_int_zero_write: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_sts_lo && !sts_clear && !i_int_event |=> $stable(int_status))
      else $error("writing zero changed interrupt status");

   a_intx_gate: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      1'b1 |=> o_intx_n == !($past(int_status) && !$past(int_dis_reg)))
      else $error("interrupt pin does not follow status and disable");

   a_dis_keeps_sts: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_cmd_hi && !wr_sts_lo && !i_int_event
      |=> $stable(int_status) ##1 o_intx_n == !($past(int_status) && !$past(int_dis_reg)))
      else $error("disable write disturbed interrupt status");

   a_dis_write: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      wr_cmd_hi |=> int_dis_reg == $past(i_cfg_wdata[gps_pkg::CMD_INT_DIS_BIT]))
      else $error("interrupt disable not written");

   a_rev_read: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && hit_rev |=> o_cfg_ack && (o_cfg_rdata == {24'h00_0000, REVISION}))
      else $error("revision read wrong");

   a_rsvd_zero: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && hit_cmd_sts
      |=> o_cfg_rdata[gps_pkg::STS_LANE_LO + gps_pkg::STS_RSVD_HI:gps_pkg::STS_LANE_LO] == 3'h0)
      else $error("reserved status bits not zero");

   a_unmapped_zero: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && !hit_cmd_sts && !hit_rev |=> o_cfg_rdata == 32'h0000_0000)
      else $error("unmapped read not zero");

   // ********************************************
   // read-back and output checks
   // ********************************************
   a_reset_outputs: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      first_reg |-> o_intx_n && !o_cfg_ack && !o_int_disable &&
                    (o_cfg_rdata == 32'h0000_0000))
      else $error("outputs not at reset values");

   a_sts_high_zero: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && hit_cmd_sts
      |=> o_cfg_rdata[31:24] == 8'h00)
      else $error("status error bits not zero");

   a_sts_caps: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && hit_cmd_sts
      |=> o_cfg_rdata[23:20] == 4'h9)
      else $error("status capability bits wrong");

   a_int_bit_read: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && hit_cmd_sts
      |=> o_cfg_rdata[19] == $past(int_status))
      else $error("interrupt status bit read wrong");

   a_cmd_read: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && hit_cmd_sts
      |=> o_cfg_rdata[15:0] == {5'h00, $past(int_dis_reg), 10'h000})
      else $error("command word read wrong");

   a_write_no_data: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      i_cfg_wr |=> o_cfg_ack && (o_cfg_rdata == 32'h0000_0000))
      else $error("write answered with data");

   a_ack_one_cycle: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      req |=> o_cfg_ack)
      else $error("request not answered next cycle");

   a_dis_holds: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !wr_cmd_hi |=> $stable(int_dis_reg))
      else $error("interrupt disable changed without write");

   a_sts_holds: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !i_int_event && !sts_clear |=> $stable(int_status))
      else $error("interrupt status changed without cause");

   a_intx_masked: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      int_dis_reg |=> o_intx_n)
      else $error("interrupt pin asserted while disabled");

   a_rev_shared: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && (i_cfg_addr[7:2] == gps_pkg::REV_OFFSET[7:2]) && (i_cfg_func <= 3'h1)
      |=> o_cfg_rdata == {24'h00_0000, REVISION})
      else $error("revision differs between functions");

   a_func_unmapped: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      rd_take && (i_cfg_func > 3'h1) |=> o_cfg_rdata == 32'h0000_0000)
      else $error("unmapped function read not zero");

   a_intx_idle: assert property (
      @(posedge i_ref_clk) disable iff (!i_reset_n)
      !int_status |=> o_intx_n)
      else $error("interrupt pin asserted without status");

endmodule

`default_nettype wire

// >>> dv/gps_host_model.sv
// Purpose: configuration host model that issues read and write requests
// Assumes: one request at a time, launched at the falling edge
// Notes:   idle lines show inverted values, so a stale value never passes

`timescale 1ns/10ps
`default_nettype none

module gps_host_model (
   input  wire logic        i_ref_clk,
   input  wire logic        i_cfg_ack,
   input  wire logic [31:0] i_cfg_rdata,
   output logic             o_cfg_rd,
   output logic             o_cfg_wr,
   output logic [7:0]       o_cfg_addr,
   output logic [2:0]       o_cfg_func,
   output logic [3:0]       o_cfg_be,
   output logic [31:0]      o_cfg_wdata
);
   // ***********************
   // request driver
   // ***********************
   initial begin
      o_cfg_rd    = 1'b0;
      o_cfg_wr    = 1'b0;
      o_cfg_addr  = 8'hff;
      o_cfg_func  = 3'h7;
      o_cfg_be    = 4'h0;
      o_cfg_wdata = 32'h0;
   end

   // answer is registered at the taking edge and read half a cycle later, so no wait loop
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [2:0] f,
                       input logic [3:0] be, input logic [31:0] d,
                       output logic [31:0] q, output logic ack);
      @(negedge i_ref_clk);
      o_cfg_rd    = !wr;
      o_cfg_wr    = wr;
      o_cfg_addr  = a;
      o_cfg_func  = f;
      o_cfg_be    = be;
      o_cfg_wdata = d;
      @(negedge i_ref_clk);
      o_cfg_rd    = 1'b0;
      o_cfg_wr    = 1'b0;
      o_cfg_addr  = ~a;
      o_cfg_func  = ~f;
      o_cfg_be    = ~be;
      o_cfg_wdata = ~d;
      ack         = i_cfg_ack;
      q           = i_cfg_rdata;
   endtask

   // two reads with no idle cycle between them
   task automatic xfer_pair(input logic [7:0] a0, input logic [7:0] a1,
                            output logic [31:0] q0, output logic [31:0] q1,
                            output logic k0, output logic k1);
      @(negedge i_ref_clk);
      o_cfg_rd    = 1'b1;
      o_cfg_wr    = 1'b0;
      o_cfg_addr  = a0;
      o_cfg_func  = 3'h0;
      o_cfg_be    = 4'h0;
      o_cfg_wdata = 32'h0;
      @(negedge i_ref_clk);
      o_cfg_addr  = a1;
      k0          = i_cfg_ack;
      q0          = i_cfg_rdata;
      @(negedge i_ref_clk);
      o_cfg_rd    = 1'b0;
      o_cfg_addr  = ~a1;
      o_cfg_func  = 3'h7;
      o_cfg_be    = 4'hf;
      o_cfg_wdata = 32'hffff_ffff;
      k1          = i_cfg_ack;
      q1          = i_cfg_rdata;
   endtask
endmodule

`default_nettype wire

// >>> dv/gps_regs_tb.sv
// Purpose: self-checking bench for the status and revision registers
// Assumes: inputs change at the falling edge only
// Notes:   revision parameter set off its default to prove it is passed on

`timescale 1ns/10ps
`default_nettype none

module gps_regs_tb;
   // arbitrary revision value
   localparam logic [7:0] REV = 8'h3c;
   logic        clk;
   logic        rst_n;
   logic        ev;
   logic        rd;
   logic        wr;
   logic [7:0]  addr;
   logic [2:0]  func;
   logic [3:0]  be;
   logic [31:0] wdata;
   logic        ack;
   logic [31:0] rdata;
   logic        intx_n;
   logic        serr_out;
   logic        serr_oe;
   logic        int_dis;
   int          err_count = 0;
   int          comparisons = 0;
   int          cycles = 0;

   gps_regs #(.REVISION(REV)) dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_cfg_rd(rd),
      .i_cfg_wr(wr), .i_cfg_addr(addr), .i_cfg_func(func), .i_cfg_be(be),
      .i_cfg_wdata(wdata), .i_int_event(ev), .o_cfg_ack(ack), .o_cfg_rdata(rdata),
      .o_intx_n(intx_n), .o_serr_n_out(serr_out), .o_serr_n_oe(serr_oe),
      .o_int_disable(int_dis));

   gps_host_model host (.i_ref_clk(clk), .i_cfg_ack(ack), .i_cfg_rdata(rdata),
      .o_cfg_rd(rd), .o_cfg_wr(wr), .o_cfg_addr(addr), .o_cfg_func(func),
      .o_cfg_be(be), .o_cfg_wdata(wdata));

   // ***********************
   // helpers
   // ***********************
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic rdchk(input string n, input logic [7:0] a, input logic [2:0] f,
                        input logic [31:0] e);
      logic [31:0] q;
      logic        k;
      host.xfer(1'b0, a, f, 4'h0, 32'h0, q, k);
      chk({n, " ack"}, 32'h1, {31'h0, k});
      chk(n, e, q);
   endtask

   task automatic wrt(input logic [3:0] b, input logic [31:0] d);
      logic [31:0] q;
      logic        k;
      host.xfer(1'b1, 8'h04, 3'h0, b, d, q, k);
      chk("write ack", 32'h1, {31'h0, k});
      chk("write data", 32'h0, q);
   endtask

   task automatic pulse_event();
      @(negedge clk);
      ev = 1'b1;
      @(negedge clk);
      ev = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   // ***********************
   // scenarios
   // ***********************
   task automatic t_reset_values();
      rdchk("status f0", 8'h06, 3'h0, 32'h0090_0000);
      rdchk("status f1", 8'h04, 3'h1, 32'h0090_0000);
      rdchk("rev f0", 8'h08, 3'h0, {24'h0, REV});
      rdchk("rev f1", 8'h08, 3'h1, {24'h0, REV});
      chk("intx idle", 32'h1, {31'h0, intx_n});
      chk("serr pin", 32'h0, {30'h0, serr_oe, serr_out});
   endtask

   task automatic t_write_ignored();
      logic [31:0] q;
      logic        k;
      wrt(4'b1100, 32'hfff7_0000);
      rdchk("fixed bits", 8'h06, 3'h0, 32'h0090_0000);
      host.xfer(1'b1, 8'h08, 3'h0, 4'hf, 32'hffff_ffff, q, k);
      chk("rev write ack", 32'h1, {31'h0, k});
      chk("rev write data", 32'h0, q);
      rdchk("rev write", 8'h08, 3'h0, {24'h0, REV});
      rdchk("unmapped", 8'h40, 3'h0, 32'h0);
      rdchk("func 2", 8'h06, 3'h2, 32'h0);
   endtask

   task automatic t_back_to_back();
      logic [31:0] q0;
      logic [31:0] q1;
      logic        k0;
      logic        k1;
      host.xfer_pair(8'h06, 8'h08, q0, q1, k0, k1);
      chk("pair ack 0", 32'h1, {31'h0, k0});
      chk("pair sts", 32'h0090_0000, q0);
      chk("pair ack 1", 32'h1, {31'h0, k1});
      chk("pair rev", {24'h0, REV}, q1);
   endtask

   task automatic t_interrupt();
      pulse_event();
      chk("intx set", 32'h0, {31'h0, intx_n});
      rdchk("pending", 8'h06, 3'h0, 32'h0098_0000);
      wrt(4'b0100, 32'h0);
      wrt(4'b1001, 32'h0008_0000);
      rdchk("no clear", 8'h06, 3'h0, 32'h0098_0000);
      wrt(4'b0010, 32'h0000_0400);
      @(negedge clk);
      chk("intx masked", 32'h1, {31'h0, intx_n});
      chk("disable out", 32'h1, {31'h0, int_dis});
      rdchk("masked sts", 8'h06, 3'h0, 32'h0098_0400);
      wrt(4'b0010, 32'h0);
      @(negedge clk);
      chk("intx unmask", 32'h0, {31'h0, intx_n});
      // event lands in the same cycle as the clear
      fork
         wrt(4'b0100, 32'h0008_0000);
         begin
            @(negedge clk);
            ev = 1'b1;
            @(negedge clk);
            ev = 1'b0;
         end
      join
      rdchk("set wins", 8'h06, 3'h0, 32'h0098_0000);
      chk("intx held", 32'h0, {31'h0, intx_n});
      wrt(4'b0100, 32'h0008_0000);
      rdchk("cleared", 8'h06, 3'h0, 32'h0090_0000);
      chk("intx clear", 32'h1, {31'h0, intx_n});
   endtask

   task automatic t_midrun_reset();
      pulse_event();
      wrt(4'b0010, 32'h0000_0400);
      @(negedge clk);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk("disable rst", 32'h0, {31'h0, int_dis});
      rst_n = 1'b1;
      t_reset_values();
   endtask

   // ***********************
   // run control
   // ***********************
   task automatic results();
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // run takes about 85 cycles; a hang is cut well after that
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         results();
      end
   end

   initial begin
      rst_n = 1'b0;
      ev = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      t_reset_values();
      t_write_ignored();
      t_back_to_back();
      t_interrupt();
      t_midrun_reset();
      results();
   end
endmodule

`default_nettype wire
